// ### hdl/i2p_pkg.sv
/*
 Constants, enums and carrier structs of the I2C DMA/checksum block.
 Assumes both clock domains import it.
*/
package i2p_pkg;

    // ==============================
    // Constants
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [4:0] HEADER_PREFIX = 5'h1e;

    // ==============================
    // Enumerations
    typedef enum logic [1:0] {
        EV_START = 2'b00,
        EV_STOP = 2'b01,
        EV_ADDR = 2'b10,
        EV_BYTE = 2'b11
    } i2p_evt_t;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_BITS = 3'b001,
        LK_ACK = 3'b010,
        LK_LOAD = 3'b011,
        LK_HOLD = 3'b100,
        LK_SKIP = 3'b101
    } i2p_lstate_t;

    // ==============================
    // Carriers
    typedef struct packed {
        logic dmaRequestEnable;
        logic checksumEnable;
        logic lastTransfer;
        logic stretchDisable;
        logic eventInterruptEnable;
        logic bufferInterruptEnable;
        logic errorInterruptEnable;
        logic isMaster;
        logic headerEnable;
        logic [1:0] ownHeader;
        logic [6:0] ownAddr;
    } i2p_cfg_t;

    typedef struct packed {
        logic checksumTransferRequest;
        logic dataWrite;
        logic dataRead;
        logic haltWakeClear;
        logic checksumErrorClear;
        logic [7:0] writeData;
    } i2p_sw_t;

    typedef struct packed {
        logic txAck;
        logic [7:0] txData;
        logic rxAck;
        logic transferDoneSignal;
        logic penultimateTransferSignal;
    } i2p_dma_t;

    typedef struct packed {
        logic transmitEmptyFlag;
        logic receiveFullFlag;
        logic checksumErrorFlag;
        logic haltWakeupFlag;
        logic checksumValid;
        logic busBusy;
        logic transmitting;
        logic [7:0] checksumValue;
        logic [7:0] rxData;
    } i2p_status_t;

    // Levels that change during a transfer; each passes a two-flop synchroniser
    typedef struct packed {
        logic txFull;
        logic hold;
        logic freeze;
        logic haltSlave;
        logic sendChecksum;
        logic checksumNext;
        logic nackNext;
    } i2p_dnlvl_t;

    typedef struct packed {
        i2p_dnlvl_t lvl;
        logic [7:0] txData;
        logic checksumEnable;
        logic isMaster;
        logic stretchDisable;
        logic headerEnable;
        logic [1:0] ownHeader;
        logic [6:0] ownAddr;
    } i2p_down_t;

    typedef struct packed {
        logic evtToggle;
        logic takenToggle;
        i2p_evt_t kind;
        logic [7:0] data;
        logic [7:0] crc;
        logic crcValid;
        logic crcOk;
        logic matched;
        logic ackSeen;
    } i2p_up_t;

    function automatic logic [7:0] i2p_crc_step(input logic [7:0] crc, input logic din);
        logic fb;
        fb = crc[7] ^ din;
        return {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction

endpackage

// ### hdl/i2p_link.sv
/*
 Link-side engine: bit and byte sequencing, serial checksum,
 acknowledge decision and clock holding.
 Assumes the link clock oversamples both lines and configuration
 stays still during a transfer.
*/
`timescale 1ns/100ps
`default_nettype none

module i2p_link (
    input wire logic linkClk,
    input wire logic reset_n,
    input wire i2p_pkg::i2p_down_t down,
    output var i2p_pkg::i2p_up_t up,
    input wire logic sclIn,
    input wire logic sdaIn,
    output var logic sclOe,
    output var logic sdaOe
);
    import i2p_pkg::*;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic sclPrev;
        logic sdaPrev;
        i2p_dnlvl_t dnSync1;
        i2p_dnlvl_t dnSync2;
        logic haltPrev;
        i2p_lstate_t state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] txShift;
        logic txMode;
        logic firstByte;
        logic matched;
        logic ackSeen;
        logic [7:0] crc;
        logic crcValid;
        logic sdaOe;
        logic sclOe;
        i2p_up_t up;
    } i2p_lreg_t;

    i2p_lreg_t r;
    i2p_lreg_t n;
    logic sda, sclHi, sclRise, sclFall, busStart, busStop, addrHit, nextTx;
    logic [7:0] loadByte;
    i2p_dnlvl_t lv;

    // ==============================
    // Next state
    always_comb begin
        n = r;
        sda = r.sdaSync[1];
        lv = r.dnSync2;
        n.sclSync = {r.sclSync[0], sclIn};
        n.sdaSync = {r.sdaSync[0], sdaIn};
        n.sclPrev = r.sclSync[1];
        n.sdaPrev = sda;
        n.dnSync1 = down.lvl;
        n.dnSync2 = r.dnSync1;
        n.haltPrev = lv.haltSlave;
        sclHi = r.sclSync[1] & r.sclPrev;
        sclRise = r.sclSync[1] & !r.sclPrev;
        sclFall = !r.sclSync[1] & r.sclPrev;
        busStart = sclHi & r.sdaPrev & !sda;
        busStop = sclHi & !r.sdaPrev & sda;
        addrHit = (r.shift[7:1] == down.ownAddr) ||
                  (down.headerEnable && r.shift[7:3] == HEADER_PREFIX &&
                   r.shift[2:1] == down.ownHeader);
        nextTx = r.firstByte ? (down.isMaster ? !r.shift[0] : r.shift[0]) : r.txMode;
        // Data queued before a checksum request goes out first
        loadByte = (lv.sendChecksum && !lv.txFull) ? r.crc : down.txData;
        if (lv.haltSlave && !r.haltPrev && !down.isMaster) begin
            n.state = LK_IDLE;
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
        end else if (lv.freeze && down.isMaster && r.state != LK_IDLE) begin
            n.sclOe = 1'b1;
        end else if (busStart) begin
            n.state = down.isMaster ? LK_LOAD : LK_BITS;
            n.bitCnt = BIT_COUNT_RESET;
            n.crc = CRC_INIT;
            n.crcValid = 1'b1;
            n.firstByte = 1'b1;
            n.txMode = down.isMaster;
            n.sdaOe = 1'b0;
            n.up.evtToggle = !r.up.evtToggle;
            n.up.kind = EV_START;
        end else if (busStop) begin
            n.state = LK_IDLE;
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
            n.up.evtToggle = !r.up.evtToggle;
            n.up.kind = EV_STOP;
        end else begin
            case (r.state)
                LK_IDLE, LK_SKIP: begin
                    n.sdaOe = 1'b0;
                end
                LK_LOAD: begin
                    // Without stretching an empty buffer underruns and old data goes out
                    if (lv.txFull || lv.sendChecksum || down.stretchDisable) begin
                        n.txShift = loadByte;
                        n.up.takenToggle = !r.up.takenToggle;
                        n.sclOe = 1'b0;
                        n.sdaOe = !loadByte[7];
                        n.state = LK_BITS;
                    end else begin
                        n.sclOe = 1'b1;
                    end
                end
                LK_BITS: begin
                    if (sclRise) begin
                        n.shift = {r.shift[6:0], sda};
                        if (down.checksumEnable) begin
                            n.crc = i2p_crc_step(r.crc, sda);
                        end
                        n.bitCnt = r.bitCnt + 4'h1;
                        n.txShift = {r.txShift[6:0], 1'b0};
                        if (r.txMode && r.txShift[7] && !sda && down.isMaster) begin
                            n.crcValid = 1'b0;
                            n.txMode = 1'b0;
                            n.sdaOe = 1'b0;
                            n.state = LK_SKIP;
                        end
                    end else if (sclFall) begin
                        if (r.bitCnt == BITS_PER_BYTE) begin
                            n.state = LK_ACK;
                            if (r.txMode) begin
                                n.sdaOe = 1'b0;
                            end else if (r.firstByte) begin
                                n.matched = addrHit;
                                n.sdaOe = addrHit && !lv.haltSlave;
                            end else begin
                                n.sdaOe = !(lv.nackNext ||
                                    (lv.checksumNext && r.crc != CRC_INIT));
                            end
                        end else if (r.txMode) begin
                            n.sdaOe = !r.txShift[7];
                        end
                    end
                end
                LK_ACK: begin
                    if (sclRise) begin
                        n.ackSeen = sda;
                    end else if (sclFall) begin
                        n.sdaOe = 1'b0;
                        n.bitCnt = BIT_COUNT_RESET;
                        n.firstByte = 1'b0;
                        n.txMode = nextTx;
                        n.up.evtToggle = !r.up.evtToggle;
                        n.up.kind = r.firstByte ? EV_ADDR : EV_BYTE;
                        n.up.data = r.shift;
                        n.up.crc = r.crc;
                        n.up.crcValid = r.crcValid;
                        n.up.crcOk = (r.crc == CRC_INIT);
                        n.up.matched = r.matched;
                        n.up.ackSeen = r.ackSeen;
                        if (r.firstByte && !down.isMaster && !r.matched) begin
                            n.state = LK_SKIP;
                        end else if (r.firstByte && !down.isMaster && lv.haltSlave) begin
                            n.state = down.stretchDisable ? LK_SKIP : LK_HOLD;
                            n.sclOe = !down.stretchDisable;
                        end else if ((r.txMode && r.ackSeen) ||
                                     (!r.txMode && !r.firstByte && !r.sdaOe)) begin
                            n.state = LK_SKIP;
                        end else begin
                            n.state = nextTx ? LK_LOAD : LK_BITS;
                        end
                    end
                end
                LK_HOLD: begin
                    // The waking address got no acknowledge, so the transfer is dropped
                    n.sclOe = lv.hold;
                    if (!lv.hold) begin
                        n.state = LK_SKIP;
                    end
                end
                default: begin
                    n.state = LK_IDLE;
                end
            endcase
        end
    end

    // ==============================
    // State register
    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign up = r.up;
    assign sclOe = r.sclOe;
    assign sdaOe = r.sdaOe;

endmodule

`default_nettype wire

// ### hdl/i2p_top.sv
/*
 System-side top of the I2C DMA, checksum and low-power block:
 buffering for software and DMA, checksum sequencing,
 halt wakeup, and the crossing to the link engine.
 Assumes DMA and software on sys_clk, a separate link clock
 and open-drain lines resolved outside.
*/
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Transmit DMA request while data buffer empty, outside halt, no checksum byte pending
// - Receive DMA request whenever a byte arrives
// - Checksum is serial CRC-8, polynomial 0x07
// - Checksum covers every bus byte, address included; the link restarts it at every start, repeated start included
// - Requested checksum byte follows last transmitted byte
// - Received checksum mismatch gets NACK
// - Master receiver always NACKs the checksum byte
// - Mismatch sets sticky checksum error flag
// - DMA done in transmit triggers checksum send
// - DMA penultimate in receive marks next as checksum
// - Last-transfer bit makes master NACK final byte
// - Arbitration loss clears link crcValid only; status checksumValid keeps its value
// - Wait modes unchanged; interrupts request wakeup
// - Slave halt resets communication, keeps configuration
// - Halted slave address match sets wakeup flag
// - Waking address not acknowledged, no flags
// - Clock held low until halt ends and wakeup flag cleared
// - Master halt freezes bus; wakeup flag on exit
module i2p_top (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire i2p_pkg::i2p_cfg_t cfg,
    input wire i2p_pkg::i2p_sw_t sw,
    input wire i2p_pkg::i2p_dma_t dma,
    input wire logic waitMode,
    input wire logic haltMode,
    output var logic dmaTxReq,
    output var logic dmaRxReq,
    output var i2p_pkg::i2p_status_t status,
    output var logic irqReq,
    output var logic wakeRequest,
    input wire logic sclIn,
    output var logic sclOut,
    output var logic sclOe,
    input wire logic sdaIn,
    output var logic sdaOut,
    output var logic sdaOe
);
    import i2p_pkg::*;

    typedef struct packed {
        logic [1:0] upSync1;
        logic [1:0] upSync2;
        logic [1:0] togPrev;
        logic haltPrev;
        logic busy;
        logic inTx;
        logic txFull;
        logic [7:0] txData;
        logic rxFull;
        logic [7:0] rxData;
        logic pecReq;
        logic sendChecksum;
        logic checksumNext;
        logic nackNext;
        logic checksum_error_flag;
        logic wakeFlag;
        logic crcValid;
        logic [7:0] pecValue;
        i2p_down_t down;
    } i2p_sreg_t;

    i2p_sreg_t r;
    i2p_sreg_t n;
    i2p_up_t up;
    logic evtSeen, takenSeen, slaveHalt, rxSide, txEmptyEvent;

    // ==============================
    // Link-side engine
    i2p_link u_link (
        .linkClk(linkClk),
        .reset_n(reset_n),
        .down(r.down),
        .up(up),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sclOe(sclOe),
        .sdaOe(sdaOe)
    );

    // ==============================
    // Next state
    always_comb begin
        n = r;
        // Toggles cross by two flops; event fields settle long before
        evtSeen = r.upSync2[0] ^ r.togPrev[0];
        takenSeen = r.upSync2[1] ^ r.togPrev[1];
        slaveHalt = haltMode && !cfg.isMaster;
        rxSide = !r.inTx;
        if (clkEn) begin
            n.upSync1 = {up.takenToggle, up.evtToggle};
            n.upSync2 = r.upSync1;
            n.togPrev = r.upSync2;
            n.haltPrev = haltMode;

            // Clears first, so any set below in the same cycle wins
            if (takenSeen) begin
                if (r.txFull) begin
                    n.txFull = 1'b0;
                end else begin
                    n.sendChecksum = 1'b0;
                    n.pecReq = 1'b0;
                end
            end
            if (sw.dataRead || dma.rxAck) begin
                n.rxFull = 1'b0;
            end
            if (sw.checksumErrorClear) begin
                n.checksum_error_flag = 1'b0;
            end
            if (sw.haltWakeClear) begin
                n.wakeFlag = 1'b0;
            end

            if (evtSeen) begin
                n.pecValue = up.crc;
                n.crcValid = up.crcValid;
                case (up.kind)
                    EV_START, EV_STOP: begin
                        n.busy = (up.kind == EV_START);
                        n.inTx = cfg.isMaster;
                        n.pecReq = 1'b0;
                        n.sendChecksum = 1'b0;
                        n.checksumNext = 1'b0;
                        n.nackNext = 1'b0;
                    end
                    EV_ADDR: begin
                        if (slaveHalt) begin
                            if (up.matched && cfg.eventInterruptEnable) begin
                                n.wakeFlag = 1'b1;
                            end
                        end else begin
                            n.inTx = cfg.isMaster ? !up.data[0] : up.data[0];
                        end
                    end
                    EV_BYTE: begin
                        if (rxSide && !slaveHalt) begin
                            n.rxData = up.data;
                            n.rxFull = 1'b1;
                        end
                        if (rxSide) begin
                            if (r.checksumNext) begin
                                if (!up.crcOk) begin
                                    n.checksum_error_flag = 1'b1;
                                end
                                n.pecReq = 1'b0;
                            end
                            n.checksumNext = 1'b0;
                            n.nackNext = 1'b0;
                        end
                    end
                    default: begin
                        n.busy = r.busy;
                    end
                endcase
            end

            // Checksum requests from software
            if (sw.checksumTransferRequest) begin
                n.pecReq = 1'b1;
                if (r.inTx) begin
                    n.sendChecksum = 1'b1;
                end else begin
                    n.checksumNext = 1'b1;
                    if (cfg.isMaster) begin
                        n.nackNext = 1'b1;
                    end
                end
            end

            // Checksum requests from the DMA controller's terminal signals
            if (cfg.dmaRequestEnable && cfg.checksumEnable && r.inTx &&
                dma.transferDoneSignal) begin
                n.sendChecksum = 1'b1;
            end
            if (cfg.dmaRequestEnable && rxSide && dma.penultimateTransferSignal) begin
                if (cfg.checksumEnable) begin
                    n.checksumNext = 1'b1;
                    if (cfg.isMaster) begin
                        n.nackNext = 1'b1;
                    end
                end
                if (cfg.lastTransfer && cfg.isMaster) begin
                    n.nackNext = 1'b1;
                end
            end

            // Buffer writes from software or DMA
            if (sw.dataWrite) begin
                n.txFull = 1'b1;
                n.txData = sw.writeData;
            end else if (dma.txAck) begin
                n.txFull = 1'b1;
                n.txData = dma.txData;
            end

            // A master only learns of halt at its exit
            if (r.haltPrev && !haltMode && cfg.isMaster && cfg.eventInterruptEnable) begin
                n.wakeFlag = 1'b1;
            end

            // Levels toward the link domain, registered so no glitch crosses
            n.down.lvl.txFull = n.txFull;
            n.down.lvl.hold = (haltMode || n.wakeFlag) && !cfg.stretchDisable;
            n.down.lvl.freeze = haltMode && cfg.isMaster;
            n.down.lvl.haltSlave = slaveHalt;
            n.down.lvl.sendChecksum = n.sendChecksum;
            n.down.lvl.checksumNext = n.checksumNext;
            n.down.lvl.nackNext = n.nackNext;
            n.down.txData = n.txData;
            n.down.checksumEnable = cfg.checksumEnable;
            n.down.isMaster = cfg.isMaster;
            n.down.stretchDisable = cfg.stretchDisable;
            n.down.headerEnable = cfg.headerEnable;
            n.down.ownHeader = cfg.ownHeader;
            n.down.ownAddr = cfg.ownAddr;
        end
    end

    // ==============================
    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ==============================
    // Requests and status
    // No request while a checksum byte is pending
    assign dmaTxReq = cfg.dmaRequestEnable && r.busy && r.inTx && !r.txFull &&
                      !r.sendChecksum && !haltMode;
    assign dmaRxReq = cfg.dmaRequestEnable && r.rxFull;
    assign txEmptyEvent = r.busy && r.inTx && !r.txFull;

    // Buffer events need both enables; DMA users keep one off
    assign irqReq = (cfg.eventInterruptEnable &&
                     (r.wakeFlag || (cfg.bufferInterruptEnable &&
                                     (r.rxFull || txEmptyEvent)))) ||
                    (cfg.errorInterruptEnable && r.checksum_error_flag);
    assign wakeRequest = waitMode ? irqReq : (haltMode && r.wakeFlag);

    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    assign status.transmitEmptyFlag = !r.txFull;
    assign status.receiveFullFlag = r.rxFull;
    assign status.checksumErrorFlag = r.checksum_error_flag;
    assign status.haltWakeupFlag = r.wakeFlag;
    assign status.checksumValid = r.crcValid;
    assign status.busBusy = r.busy;
    assign status.transmitting = r.inTx;
    assign status.checksumValue = r.pecValue;
    assign status.rxData = r.rxData;

endmodule

`default_nettype wire

// ### dv/i2p_top_sva.sv
/*
 Port checker for the DMA request, checksum and low-power top.
 Assumes it is bound into every top instance, sys_clk domain only.
*/
`timescale 1ns/100ps
`default_nettype none
module i2p_top_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire i2p_pkg::i2p_cfg_t cfg,
    input wire i2p_pkg::i2p_sw_t sw,
    input wire i2p_pkg::i2p_dma_t dma,
    input wire logic waitMode,
    input wire logic haltMode,
    input wire logic dmaTxReq,
    input wire logic dmaRxReq,
    input wire i2p_pkg::i2p_status_t status,
    input wire logic irqReq,
    input wire logic wakeRequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ==============================
    // Assertions
    a_txreq_cause: assert property (dmaTxReq |-> status.transmitEmptyFlag && !haltMode)
        else $error("tx request bad");
    a_rxreq_level: assert property (dmaRxReq == (cfg.dmaRequestEnable && status.receiveFullFlag))
        else $error("rx request bad");
    a_write_fills: assert property (sw.dataWrite || dma.txAck |=> !status.transmitEmptyFlag)
        else $error("buffer not filled");
    a_wait_wake: assert property (waitMode |-> wakeRequest == irqReq)
        else $error("wait wakeup bad");
    a_halt_wake: assert property (haltMode && !waitMode |-> wakeRequest == status.haltWakeupFlag)
        else $error("halt wakeup bad");
    a_err_sticky: assert property (status.checksumErrorFlag && !sw.checksumErrorClear |=>
        status.checksumErrorFlag) else $error("error flag lost");
    a_err_irq: assert property (cfg.errorInterruptEnable && status.checksumErrorFlag |-> irqReq)
        else $error("error irq missing");
    a_wake_cause: assert property ($rose(status.haltWakeupFlag) |-> cfg.eventInterruptEnable)
        else $error("wake flag unexpected");
    c_txreq: cover property (dmaTxReq);
    c_rxreq: cover property ($rose(dmaRxReq));
    c_err: cover property ($rose(status.checksumErrorFlag));
endmodule
bind i2p_top i2p_top_sva i2p_top_sva_i (.sys_clk, .reset_n, .cfg, .sw, .dma, .waitMode,
    .haltMode, .dmaTxReq, .dmaRxReq, .status, .irqReq, .wakeRequest);
`default_nettype wire

// ### dv/i2p_peer.sv
/*
 Bus master peer driving both open-drain lines.
 Assumes the bench resolves each wire from all pull-downs.
*/
`timescale 1ns/100ps
`default_nettype none
module i2p_peer (
    input wire logic scl,
    input wire logic sda,
    output var logic sclPull,
    output var logic sdaPull
);
    logic ackBit;
    logic [7:0] rxByte;
    initial begin
        sclPull = 0;
        sdaPull = 0;
    end
    // Slave may stretch; a stuck line ends the run as a failure
    task waitScl();
        for (int k = 0; k < 99 && scl !== 1'b1; k++) #500;
        if (scl !== 1'b1) i2p_dma_pec_lowpower_test.abort();
    endtask
    task start();
        sdaPull = 0;
        #2000 sclPull = 0;
        waitScl();
        #2000 sdaPull = 1;
        #2000 sclPull = 1;
    endtask
    task stop();
        #500 sdaPull = 1;
        #2000 sclPull = 0;
        waitScl();
        #2000 sdaPull = 0;
        #2000;
    endtask
    // Last bit is the acknowledge slot
    task xfer(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            #500 sdaPull = !b[i];
            #2000 sclPull = 0;
            waitScl();
            #2000 rxByte = {rxByte[6:0], ackBit};
            ackBit = sda;
            sclPull = 1;
        end
    endtask
endmodule
`default_nettype wire

// ### dv/i2p_dma_pec_lowpower_test.sv
/*
 Bench: bus peer plus DMA and software played by the bench.
 Assumes the checker is bound in by its own file.
*/
`timescale 1ns/100ps
`default_nettype none
module i2p_dma_pec_lowpower_test;
    import i2p_pkg::*;
    logic sys_clk = 0, linkClk = 0, reset_n = 0, waitMode = 0, haltMode = 0;
    i2p_cfg_t cfg = '0;
    i2p_sw_t sw = '0;
    i2p_dma_t dma = '0;
    i2p_status_t status;
    logic dmaTxReq, dmaRxReq, irqReq, wakeRequest, sclOe, sdaOe, sclPull, sdaPull;
    wire logic scl = !(sclOe | sclPull);
    wire logic sda = !(sdaOe | sdaPull);
    int n_mismatch = 0, samples_checked = 0, seed = 21;
    logic [7:0] q[$];
    logic [7:0] d;
    logic [6:0] addr;
    always #50 sys_clk = !sys_clk;
    initial #7 forever #24 linkClk = !linkClk;
    i2p_top i2p_top_i (.sys_clk, .reset_n, .clkEn(1'b1), .linkClk, .cfg, .sw, .dma, .waitMode,
        .haltMode, .dmaTxReq, .dmaRxReq, .status, .irqReq, .wakeRequest, .sclIn(scl),
        .sclOut(), .sclOe, .sdaIn(sda), .sdaOut(), .sdaOe);
    i2p_peer i2p_peer_i (.scl, .sda, .sclPull, .sdaPull);
    function logic [7:0] crcOf();
        logic [7:0] c;
        c = CRC_INIT;
        foreach (q[j])
            for (int i = 7; i >= 0; i--)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ q[j][i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_of_test();
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task abort();
        n_mismatch++;
        end_of_test();
    endtask
    task waitFor(input bit tx);
        for (int k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            if ((tx ? dmaTxReq : status.receiveFullFlag) === 1'b1) return;
        end
        abort();
    endtask
    task pulse(input i2p_sw_t s, input i2p_dma_t m);
        @(negedge sys_clk);
        sw = s;
        dma = m;
        @(negedge sys_clk);
        sw = '0;
        dma = '0;
    endtask
    // Good message checks via DMA, bad one via software
    task msg(input logic bad);
        q = '{{addr, 1'b0}};
        d = $random(seed);
        q.push_back(d);
        i2p_peer_i.start();
        i2p_peer_i.xfer({addr, 2'b01});
        chk(i2p_peer_i.ackBit, 1'b0);
        i2p_peer_i.xfer({d, 1'b1});
        waitFor(0);
        chk(status.rxData, d);
        chk(dmaRxReq, 1'b1);
        chk(status.checksumValue, crcOf());
        chk({status.busBusy, status.checksumValid}, 2'h3);
        pulse('{checksumTransferRequest: bad, default: 0},
            '{rxAck: 1, penultimateTransferSignal: !bad, default: 0});
        chk(status.receiveFullFlag, 1'b0);
        i2p_peer_i.xfer({crcOf() ^ {7'h00, bad}, 1'b1});
        chk(i2p_peer_i.ackBit, bad);
        waitFor(0);
        pulse('0, '{rxAck: 1, default: 0});
        chk(status.checksumErrorFlag, bad);
        i2p_peer_i.stop();
    endtask
    initial begin
        addr = $random(seed);
        cfg = '{dmaRequestEnable: 1, checksumEnable: 1, eventInterruptEnable: 1,
            errorInterruptEnable: 1, ownAddr: addr, default: 0};
        repeat (12) @(negedge sys_clk);
        reset_n = 1;
        chk(dmaTxReq, 1'b0);
        msg(1'b0);
        msg(1'b1);
        chk(irqReq, 1'b1);
        waitMode = 1;
        @(negedge sys_clk);
        chk(wakeRequest, 1'b1);
        waitMode = 0;
        pulse('{checksumErrorClear: 1, default: 0}, '0);
        chk(status.checksumErrorFlag, 1'b0);
        haltMode = 1;
        i2p_peer_i.start();
        i2p_peer_i.xfer({addr, 2'b01});
        chk(i2p_peer_i.ackBit, 1'b1);
        repeat (10) @(negedge sys_clk);
        chk(status.haltWakeupFlag, 1'b1);
        chk(status.receiveFullFlag, 1'b0);
        chk(wakeRequest, 1'b1);
        chk(sclOe, 1'b1);
        haltMode = 0;
        pulse('{haltWakeClear: 1, default: 0}, '0);
        chk(status.haltWakeupFlag, 1'b0);
        q = '{{addr, 1'b1}};
        d = $random(seed);
        q.push_back(d);
        i2p_peer_i.start();
        i2p_peer_i.xfer({addr, 2'b11});
        chk(i2p_peer_i.ackBit, 1'b0);
        waitFor(1);
        pulse('0, '{txAck: 1, txData: d, default: 0});
        chk(status.transmitEmptyFlag, 1'b0);
        chk(status.transmitting, 1'b1);
        pulse('0, '{transferDoneSignal: 1, default: 0});
        i2p_peer_i.xfer(9'h1fe);
        chk(i2p_peer_i.rxByte, d);
        i2p_peer_i.xfer(9'h1ff);
        chk(i2p_peer_i.rxByte, crcOf());
        i2p_peer_i.stop();
        end_of_test();
    end
endmodule
`default_nettype wire
